// ==== rtl/sac_device.sv ====
// Converter end: conversion sequencing and serial readout.
// Assumes cs_n and the select pin come from the host asynchronously;
// readout runs on the serial clock, which stands still between frames.
`timescale 1ns/1ns
`include "sac_defs.svh"

module sac_device
    import sac_pkg::*;
#(
    parameter int RES_W       = `SAC_RES_W,
    parameter int CONV_CYC    = `SAC_CONV_CYC,
    parameter bit INT_REF_VAR = 1'b1
) (
    input  wire logic             sys_clk,      // Internal timing clock
    input  wire logic             rst_b,        // Async reset, active low
    sac_link_if.dev               link,         // Serial link pins
    input  wire logic [RES_W-1:0] analog_code,  // Input as a code
    output logic                  track_hold,   // High while holding
    output logic                  shutdown,     // Low power state
    output logic                  int_ref_en,   // Internal reference on
    output logic                  conv_busy     // Conversion running
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam int TW = $clog2(CONV_CYC + 1);
    localparam logic [TW-1:0] CONV_LOAD = TW'(CONV_CYC);
    localparam logic [`SAC_CNT_W-1:0] LAST_FALL = `SAC_CNT_W'(`SAC_FRAME_FALLS);
    localparam logic [`SAC_CNT_W-1:0] RES_TOP = `SAC_CNT_W'(RES_W);

    sac_dev_state_t       state;
    sac_dev_state_t       next_state;
    logic [TW-1:0]        conv_cnt;
    logic [TW-1:0]        next_conv_cnt;
    logic [RES_W-1:0]     held_code;
    logic [RES_W-1:0]     result;
    logic                 eoc;
    logic                 next_eoc;
    logic                 drive;

    logic                 cs_meta;
    logic                 cs_sync;
    logic                 cs_prev;
    logic [1:0]           lps_meta;
    logic [1:0]           lps_sync;

    logic                 cs_fall;
    logic                 want_shut;
    logic                 conv_end;

    logic                 frame_rst_b;
    logic [`SAC_CNT_W-1:0] fall_cnt;
    logic [`SAC_CNT_W-1:0] next_fall_cnt;
    logic [`SAC_CNT_W-1:0] bit_idx;
    logic                 bit_q;
    logic                 next_bit;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cs_meta  <= 1'b1;
            cs_sync  <= 1'b1;
            cs_prev  <= 1'b1;
            lps_meta <= 2'b00;
            lps_sync <= 2'b00;
        end else begin
            cs_meta  <= link.cs_n;
            cs_sync  <= cs_meta;
            cs_prev  <= cs_sync;
            lps_meta <= {link.lps_float, link.lps_n};
            lps_sync <= lps_meta;
        end
    end

    assign cs_fall = cs_prev & ~cs_sync;

    // ----------------------------------------
    // Power mode decode
    // ----------------------------------------
    // low level shuts down
    assign want_shut = ~lps_sync[1] & ~lps_sync[0];

    assign int_ref_en = INT_REF_VAR & ~want_shut & ~lps_sync[1];

    // ----------------------------------------
    // Conversion sequencer
    // ----------------------------------------
    assign conv_end = (state == DEV_CONV) && (conv_cnt == TW'(1));

    always_comb begin
        next_state    = state;
        next_conv_cnt = conv_cnt;
        next_eoc      = eoc;
        if (want_shut) begin
            next_state = DEV_SHUT;
            next_eoc   = 1'b0;
        end else begin
            unique case (state)
                DEV_SHUT: begin
                    next_state = DEV_TRACK;
                end
                DEV_TRACK, DEV_DONE: begin
                    next_state = state;
                end
                DEV_CONV: begin
                    next_conv_cnt = conv_cnt - TW'(1);
                    if (conv_end) begin
                        next_state = DEV_DONE;
                        next_eoc   = 1'b1;
                    end
                end
            endcase
            if (cs_fall && state != DEV_SHUT) begin
                next_state    = DEV_CONV;
                next_conv_cnt = CONV_LOAD;
                next_eoc      = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state    <= DEV_TRACK;
            conv_cnt <= '0;
            eoc      <= 1'b0;
            drive    <= 1'b0;
        end else begin
            state    <= next_state;
            conv_cnt <= next_conv_cnt;
            eoc      <= next_eoc;
            drive    <= ~cs_sync;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            held_code <= '0;
        end else if (cs_fall && state != DEV_SHUT && !want_shut) begin
            held_code <= analog_code;
        end
    end

    // Result stays put until the next conversion ends
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            result <= '0;
        end else if (conv_end && !want_shut && !cs_fall) begin
            result <= held_code;
        end
    end

    assign track_hold = (state == DEV_CONV);
    assign conv_busy  = (state == DEV_CONV);
    assign shutdown   = (state == DEV_SHUT);

    // ----------------------------------------
    // Readout on the serial clock
    // ----------------------------------------
    // Select high clears the frame; the serial clock may stop anytime.
    assign frame_rst_b = rst_b & ~link.cs_n;

    // Falls past the thirteenth only saturate the count
    assign next_fall_cnt = (fall_cnt == LAST_FALL) ? fall_cnt
                                                   : fall_cnt + `SAC_CNT_W'(1);
    assign bit_idx = RES_TOP - next_fall_cnt;

    // Result is only read after the done bit showed, when it has been
    // still for a long while; the host's clocking rules guarantee this.
    // MSB first, straight binary
    assign next_bit = (next_fall_cnt <= RES_TOP) ? result[bit_idx] : 1'b0;

    always_ff @(negedge link.sclk or negedge frame_rst_b) begin
        if (!frame_rst_b) begin
            fall_cnt <= '0;
            bit_q    <= 1'b0;
        end else begin
            fall_cnt <= next_fall_cnt;
            bit_q    <= next_bit;
        end
    end

    // ----------------------------------------
    // Data pin
    // ----------------------------------------
    // done bit leads the stream
    assign link.dout_o    = (fall_cnt == '0) ? eoc : bit_q;
    assign link.dout_oe_n = ~drive;

endmodule : sac_device

// ==== rtl/sac_defs.svh ====
// Constants for the serial SAR converter link: widths, times, counts.
// Assumes sys_clk at 20 MHz; times are in ns, counts derived from them.
//
// Behaviour
// - Select fall holds input, starts conversion
// - Conversion lasts 8.5 us, then output high
// - Stream: done bit, then 12 bits MSB first
// - Low power select low means shutdown
// - Select high: internal reference; floating: external
// - Host waits 20 ms after power up
// - Host keeps serial clock idle during conversion
// - Serial clock phases at least 100 ns each
// - Track again when conversion ends
// - Host allows 1.5 us acquisition between conversions
// - Host clocks data only after done bit
// - Output changes on falling edges, MSB first
// - Host gives at least 13 falling edges
// - Extra edges give zeros, no other effect
// - Output floats while select high, low at fall
`ifndef SAC_DEFS_SVH
`define SAC_DEFS_SVH

// ----------------------------------------
// Data format
// ----------------------------------------
`define SAC_RES_W         12
`define SAC_FRAME_FALLS   13
`define SAC_CNT_W         4

// ----------------------------------------
// Times and cycle counts
// ----------------------------------------
`define SAC_SYS_CLK_NS    50
`define SAC_CONV_NS       8500
`define SAC_ACQ_NS        1500
`define SAC_WAKE_NS       2000
`define SAC_PWRUP_NS      20000000
`define SAC_PHASE_NS      100
`define SAC_CONV_CYC  ((`SAC_CONV_NS + `SAC_SYS_CLK_NS - 1) / `SAC_SYS_CLK_NS)
`define SAC_ACQ_CYC   ((`SAC_ACQ_NS + `SAC_SYS_CLK_NS - 1) / `SAC_SYS_CLK_NS)
`define SAC_WAKE_CYC  ((`SAC_WAKE_NS + `SAC_SYS_CLK_NS - 1) / `SAC_SYS_CLK_NS)
`define SAC_PWRUP_CYC ((`SAC_PWRUP_NS + `SAC_SYS_CLK_NS - 1) / `SAC_SYS_CLK_NS)
`define SAC_PHASE_CYC ((`SAC_PHASE_NS + `SAC_SYS_CLK_NS - 1) / `SAC_SYS_CLK_NS)

`endif

// ==== rtl/sac_pkg.sv ====
// Types shared by both ends of the converter link.
// Assumes sac_defs.svh for all numeric constants.
package sac_pkg;

    typedef enum logic [1:0] {
        DEV_SHUT  = 2'b00,
        DEV_TRACK = 2'b01,
        DEV_CONV  = 2'b10,
        DEV_DONE  = 2'b11
    } sac_dev_state_t;

    typedef enum logic [2:0] {
        HOST_PWRUP = 3'b000,
        HOST_IDLE  = 3'b001,
        HOST_WAKE  = 3'b010,
        HOST_CONV  = 3'b011,
        HOST_SHIFT = 3'b100,
        HOST_ACQ   = 3'b101
    } sac_host_state_t;

    typedef enum logic [1:0] {
        REF_SHUT = 2'b00,
        REF_INT  = 2'b01,
        REF_EXT  = 2'b10
    } sac_ref_mode_t;

endpackage : sac_pkg

// ==== rtl/sac_link_if.sv ====
// Three-wire link plus the three-level low power select pin.
// Assumes the bench joins host and device through this interface.
`timescale 1ns/1ns
interface sac_link_if;
    logic sclk;         // Serial clock, made by host
    logic cs_n;         // Conversion select, active low
    logic dout_o;       // Device data drive value
    logic dout_oe_n;    // Device data enable, low drives
    logic dout;         // Resolved data line
    logic lps_n_o;      // Host low power select value
    logic lps_n_oe_n;   // Host low power select enable
    logic lps_n;        // Resolved select level
    logic lps_float;    // Select left floating

    // Undriven data line settles low through a weak pull
    assign dout      = dout_oe_n ? 1'b0 : dout_o;
    assign lps_float = lps_n_oe_n;
    assign lps_n     = lps_n_oe_n ? 1'b1 : lps_n_o;

    modport dev (
        input  sclk, cs_n, lps_n, lps_float,
        output dout_o, dout_oe_n
    );
    modport host (
        input  dout,
        output sclk, cs_n, lps_n_o, lps_n_oe_n
    );
endinterface : sac_link_if

// ==== rtl/sac_host.sv ====
// Controller end: starts conversions, makes the serial clock, reads data.
// Assumes the device answers on the data line; all pins run on sys_clk.
`timescale 1ns/1ns
`include "sac_defs.svh"

module sac_host
    import sac_pkg::*;
#(
    parameter int RES_W     = `SAC_RES_W,
    parameter int PWRUP_CYC = `SAC_PWRUP_CYC,
    parameter int ACQ_CYC   = `SAC_ACQ_CYC,
    parameter int WAKE_CYC  = `SAC_WAKE_CYC,
    parameter int PHASE_CYC = `SAC_PHASE_CYC
) (
    input  wire logic             sys_clk,      // System clock
    input  wire logic             rst_b,        // Async reset, active low
    sac_link_if.host              link,         // Serial link pins
    input  sac_ref_mode_t         ref_mode,     // Requested power mode
    input  wire logic             start,        // Conversion request
    output logic                  ready,        // Request can be taken
    output logic [RES_W-1:0]      result,       // Last result
    output logic                  result_valid  // One-cycle result strobe
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    localparam int WW = $clog2(PWRUP_CYC + ACQ_CYC + WAKE_CYC + 1);
    localparam int PW = $clog2(PHASE_CYC + 1);
    localparam logic [`SAC_CNT_W-1:0] LAST_FALL = `SAC_CNT_W'(`SAC_FRAME_FALLS);

    sac_host_state_t      state;
    sac_ref_mode_t        lps_mode;
    logic [WW-1:0]        wait_cnt;
    logic [PW-1:0]        phase_cnt;
    logic [`SAC_CNT_W-1:0] fall_cnt;
    logic [RES_W-1:0]     shreg;
    logic                 dout_meta;
    logic                 dout_sync;
    logic                 sclk_q;
    logic                 cs_q;
    logic                 wait_done;
    logic                 phase_end;
    logic                 mode_match;

    assign wait_done  = (wait_cnt == '0);
    assign phase_end  = (phase_cnt == PW'(PHASE_CYC - 1));
    assign mode_match = (ref_mode == lps_mode);
    assign ready      = (state == HOST_IDLE) && mode_match && (lps_mode != REF_SHUT);

    // ----------------------------------------
    // Pins
    // ----------------------------------------
    assign link.sclk       = sclk_q;
    assign link.cs_n       = cs_q;
    assign link.lps_n_o    = (lps_mode == REF_INT);
    assign link.lps_n_oe_n = (lps_mode == REF_EXT);

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dout_meta <= 1'b0;
            dout_sync <= 1'b0;
        end else begin
            dout_meta <= link.dout;
            dout_sync <= dout_meta;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state        <= HOST_PWRUP;
            lps_mode     <= REF_SHUT;
            wait_cnt     <= WW'(PWRUP_CYC);
            phase_cnt    <= '0;
            fall_cnt     <= '0;
            shreg        <= '0;
            result       <= '0;
            result_valid <= 1'b0;
            sclk_q       <= 1'b0;
            cs_q         <= 1'b1;
        end else begin
            result_valid <= 1'b0;
            if (!wait_done) begin
                wait_cnt <= wait_cnt - WW'(1);
            end
            unique case (state)
                HOST_PWRUP: begin
                    lps_mode <= ref_mode;
                    if (wait_done) begin
                        state <= HOST_IDLE;
                    end
                end
                HOST_IDLE: begin
                    if (!mode_match) begin
                        lps_mode <= ref_mode;
                        if (lps_mode == REF_SHUT) begin
                            state    <= HOST_WAKE;
                            wait_cnt <= WW'(WAKE_CYC);
                        end
                    end else if (start && ready) begin
                        state <= HOST_CONV;
                        cs_q  <= 1'b0;
                    end
                end
                HOST_WAKE: begin
                    if (wait_done) begin
                        state <= HOST_IDLE;
                    end
                end
                HOST_CONV: begin
                    if (dout_sync) begin
                        state     <= HOST_SHIFT;
                        phase_cnt <= '0;
                        fall_cnt  <= '0;
                    end
                end
                HOST_SHIFT: begin
                    phase_cnt <= phase_end ? '0 : phase_cnt + PW'(1);
                    if (phase_end && !sclk_q) begin
                        sclk_q <= 1'b1;
                    end else if (phase_end) begin
                        sclk_q   <= 1'b0;
                        shreg    <= {shreg[RES_W-2:0], dout_sync};
                        fall_cnt <= fall_cnt + `SAC_CNT_W'(1);
                        if (fall_cnt == LAST_FALL) begin
                            state        <= HOST_ACQ;
                            cs_q         <= 1'b1;
                            // Word is complete after the thirteenth fall;
                            // this last fall only reads a trailing zero
                            result       <= shreg;
                            result_valid <= 1'b1;
                            wait_cnt     <= WW'(ACQ_CYC);
                        end
                    end
                end
                HOST_ACQ: begin
                    if (wait_done) begin
                        state <= HOST_IDLE;
                    end
                end
                default: begin
                    state <= HOST_IDLE;
                end
            endcase
        end
    end

endmodule : sac_host

// ==== verification/sac_link_props.sv ====
// Concurrent checks on the link between host and converter.
// Assumes both ends run from sys_clk and the bench wires the link in.
`timescale 1ns/1ns
module sac_link_props (
    input wire logic sys_clk,   // System clock
    input wire logic rst_b,     // Async reset, active low
    input wire logic sclk,      // Serial clock
    input wire logic cs_n,      // Conversion select
    input wire logic dout_oe_n, // Data enable, low drives
    input wire logic dout,      // Resolved data line
    input wire logic lps_n      // Resolved low power select
);
    // ----------------------------------------
    // Helper counters
    // ----------------------------------------
    logic [4:0] fall_cnt;   // Serial falls in this frame
    logic [5:0] hi_cnt;     // Select high cycles, saturating
    logic [5:0] op_cnt;     // Cycles out of shutdown, saturating

    // Saturation keeps long idle spans from wrapping to small counts
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            fall_cnt <= 5'h00;
            hi_cnt   <= 6'h00;
            op_cnt   <= 6'h00;
        end else begin
            fall_cnt <= cs_n ? 5'h00 : fall_cnt + {4'h0, $fell(sclk) && fall_cnt != 5'h1f};
            hi_cnt   <= !cs_n ? 6'h00 : hi_cnt + {5'h00, hi_cnt != 6'h3f};
            op_cnt   <= !lps_n ? 6'h00 : op_cnt + {5'h00, op_cnt != 6'h3f};
        end
    end

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    conv_time_a: assert property (
        $fell(cs_n) && lps_n |-> ##160 !dout ##[1:20] dout)
        else $error("Done bit not at end of conversion time");
    sclk_idle_a: assert property (
        $fell(cs_n) |-> (!sclk) throughout (##160 1'b1))
        else $error("Serial clock ran during conversion");
    shift_count_a: assert property (
        $rose(cs_n) |-> fall_cnt >= 5'h0d)
        else $error("Frame closed with too few serial falls");
    sclk_high_a: assert property (
        $rose(sclk) |=> sclk)
        else $error("Serial clock high phase too short");
    sclk_low_a: assert property (
        $fell(sclk) |=> !sclk)
        else $error("Serial clock low phase too short");
    float_high_a: assert property (
        cs_n [*5] |-> dout_oe_n)
        else $error("Data line driven while select high");
    drive_on_a: assert property (
        $fell(cs_n) && lps_n |-> ##[1:4] (!dout_oe_n && !dout))
        else $error("Data line not driven low after select fall");
    trailing_zero_a: assert property (
        !cs_n && fall_cnt >= 5'h0d |-> !dout)
        else $error("Extra serial falls gave a one");
    acq_gap_a: assert property (
        $fell(cs_n) |-> hi_cnt >= 6'h1e)
        else $error("Select high gap shorter than acquisition time");
    wake_gap_a: assert property (
        $fell(cs_n) |-> op_cnt >= 6'h28)
        else $error("Conversion started inside wake delay");
endmodule : sac_link_props

// ==== verification/tb.sv ====
// Bench: host and device joined on one link, a bench-driven device on a second.
// Assumes the design files and sac_link_props.sv are compiled before it.
`timescale 1ns/1ns
`include "sac_defs.svh"
`define CHK(a, b) begin \
    checked++; \
    if ((a) !== (b)) begin \
        bad_count++; \
        $display("Error at %0t: got %h expected %h", $time, (a), (b)); \
    end \
end
module tb
    import sac_pkg::*;
;
    logic          sys_clk  = 1'b0;
    logic          rst_b    = 1'b0;
    sac_ref_mode_t ref_mode = REF_INT;
    logic          start    = 1'b0;
    logic [11:0]   code_a   = 12'h000;
    logic [11:0]   code_b   = 12'h000;
    logic [31:0]   seed     = 32'he001_6178;
    logic          ready, result_valid, shutdown, int_ref_en;
    logic          track_hold_2, shutdown_2, int_ref_en_2, conv_busy_2;
    logic [11:0]   result, exp_v;
    logic [11:0]   exp_q[$];
    int            bad_count = 0;
    int            checked   = 0;

    sac_link_if l1 ();
    sac_link_if l2 ();

    always #25 sys_clk = ~sys_clk;

    // ----------------------------------------
    // Design ends and checker
    // ----------------------------------------
    // Power-up wait kept above the wake delay and acquisition time
    sac_host #(.PWRUP_CYC(50)) u_sac_host (
        .sys_clk(sys_clk), .rst_b(rst_b), .link(l1), .ref_mode(ref_mode),
        .start(start), .ready(ready), .result(result), .result_valid(result_valid));
    sac_device u_sac_device (
        .sys_clk(sys_clk), .rst_b(rst_b), .link(l1), .analog_code(code_a),
        .track_hold(), .shutdown(shutdown), .int_ref_en(int_ref_en), .conv_busy());
    // Second device faces the bench directly, so its pins are driven exactly
    sac_device u_sac_device_2 (
        .sys_clk(sys_clk), .rst_b(rst_b), .link(l2), .analog_code(code_b),
        .track_hold(track_hold_2), .shutdown(shutdown_2), .int_ref_en(int_ref_en_2),
        .conv_busy(conv_busy_2));
    sac_link_props u_sac_link_props (
        .sys_clk(sys_clk), .rst_b(rst_b), .sclk(l1.sclk), .cs_n(l1.cs_n),
        .dout_oe_n(l1.dout_oe_n), .dout(l1.dout), .lps_n(l1.lps_n));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    task automatic stall();
        bad_count++;
        $display("Error at %0t: wait bound used up, got %h expected %h", $time, 1'b0, 1'b1);
        conclude();
    endtask : stall

    // Waits for the result too, so ready is never read at a stale edge
    task automatic host_conv(input logic [11:0] c);
        int n;
        n = 0;
        while (ready !== 1'b1) begin
            @(posedge sys_clk);
            n++;
            if (n > 3000) stall();
        end
        code_a <= c;
        start  <= 1'b1;
        exp_q.push_back(c);
        @(posedge sys_clk);
        start <= 1'b0;
        n = 0;
        while (exp_q.size() != 0) begin
            @(posedge sys_clk);
            n++;
            if (n > 3000) stall();
        end
    endtask : host_conv

    task automatic dev_frame(input logic [11:0] c);
        int n;
        code_b  <= c;
        l2.cs_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        `CHK(l2.dout_oe_n, 1'b0)
        `CHK(l2.dout, 1'b0)
        `CHK(track_hold_2, 1'b1)
        `CHK(conv_busy_2, 1'b1)
        `CHK(int_ref_en_2, !l2.lps_n_oe_n)
        n = 0;
        while (l2.dout !== 1'b1) begin
            @(posedge sys_clk);
            n++;
            if (n > 400) stall();
        end
        `CHK(n + 6 > `SAC_CONV_CYC && n + 6 < `SAC_CONV_CYC + 8, 1'b1)
        `CHK(track_hold_2, 1'b0)
        `CHK(conv_busy_2, 1'b0)
        for (int k = 0; k < 15; k++) begin
            l2.sclk <= 1'b1;
            repeat (2) @(posedge sys_clk);
            l2.sclk <= 1'b0;
            repeat (2) @(posedge sys_clk);
            `CHK(l2.dout, (k < 12) ? c[11-k] : 1'b0)
        end
        l2.cs_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK(l2.dout_oe_n, 1'b1)
        repeat (30) @(posedge sys_clk);
    endtask : dev_frame

    // ----------------------------------------
    // Result monitor and sequence
    // ----------------------------------------
    always @(posedge sys_clk) begin
        if (result_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                `CHK(1'b0, 1'b1)
            end else begin
                exp_v = exp_q.pop_front();
                `CHK(result, exp_v)
            end
        end
    end

    initial begin
        repeat (20000) @(posedge sys_clk);
        stall();
    end

    initial begin
        l2.sclk       = 1'b0;
        l2.cs_n       = 1'b1;
        l2.lps_n_o    = 1'b1;
        l2.lps_n_oe_n = 1'b0;
        repeat (3) @(posedge sys_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            ref_mode <= i[0] ? REF_EXT : REF_INT;
            host_conv(i == 0 ? 12'hfff : (i == 1 ? 12'h000 : seed[11:0]));
            `CHK(int_ref_en, !i[0])
            `CHK(shutdown, 1'b0)
        end
        $display("test host_modes done");
        ref_mode <= REF_SHUT;
        // Host only follows the mode once its acquisition wait is over
        repeat (40) @(posedge sys_clk);
        `CHK(shutdown, 1'b1)
        `CHK(ready, 1'b0)
        // A start while asleep must leave no result behind
        start <= 1'b1;
        @(posedge sys_clk);
        start    <= 1'b0;
        ref_mode <= REF_INT;
        @(posedge sys_clk);
        host_conv(12'h5a3);
        $display("test shutdown_wake done");
        dev_frame(12'ha5c);
        dev_frame(12'h001);
        seed = xs(seed);
        dev_frame(seed[11:0]);
        $display("test device_frames done");
        l2.lps_n_o <= 1'b0;
        repeat (6) @(posedge sys_clk);
        l2.cs_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        `CHK(shutdown_2, 1'b1)
        // Data pin still follows the select; no conversion starts
        `CHK(l2.dout_oe_n, 1'b0)
        `CHK(l2.dout, 1'b0)
        l2.cs_n       <= 1'b1;
        l2.lps_n_oe_n <= 1'b1;
        repeat (45) @(posedge sys_clk);
        `CHK(shutdown_2, 1'b0)
        `CHK(int_ref_en_2, 1'b0)
        dev_frame(12'h800);
        $display("test device_power done");
        conclude();
    end
endmodule : tb
